// ---- verilog/trace_map.svh ----
`ifndef TRACE_MAP_SVH
`define TRACE_MAP_SVH
// register byte offsets
`define OFF_CTL 8'h00
`define OFF_TRG 8'h04
`define OFF_STAT 8'h08
`define OFF_CNT 8'h0C
`define OFF_FH 8'h10
`define OFF_FL 8'h14
`define OFF_CAX 8'h18
`define OFF_CAH 8'h1C
`define OFF_CAL 8'h20
// field positions
`define CTL_EN_BIT 7
`define CTL_ARM_BIT 6
`define CTL_BRK_BIT 5
`define TRG_QUAL_BIT 7
`define TRG_BEGIN_BIT 6
`define TRG_EVONLY_BIT 4
`define STAT_CAPTURE_ACTIVE_FLAG_BIT 7
// reset values
`define CTL_RST 8'hC0
`define TRG_RST 8'h40
`define CAX_RST 8'h00
`define CAH_RST 8'hFF
`define CAL_RST 8'hFE
// buffer sizing and branch source offset
`define DEPTH 8
`define TALLY_FULL 4'h8
`define TALLY_LAST 4'h7
`define BRANCH_BACK 16'h0002
`endif

// ---- verilog/trace_pkg.sv ----
package trace_pkg;
    typedef enum logic [1:0] {st_idle, st_wait, st_fill, st_end} cap_state_t;
    typedef logic [15:0] entry_t;
endpackage

// ---- verilog/debug_trace_unit.sv ----
// How it works
// - buffer holds eight words; event-only entries have upper byte zero
// - indirect jump, return or vector flag stores current core address
// - taken branch stores previous cycle address minus two
// - begin capture stores nothing before trigger, then until eight words
// - end capture stores from arming; trigger clears arm and flag, stops
// - end trigger on a change of flow stores that entry last unless event-only is set
// - readout oldest first; tally stays as entries are read
// - high byte read optional; each low byte read while not armed advances buffer
// - read while armed returns oldest entry and does not advance
// - low byte read while not armed samples current opcode address
// - qualify select set: pending interrupt suppresses the trigger
// - qualify clear, end mode: trigger anyway, disarm, skip exception entry
// - qualify clear, begin mode: trigger, record flow, stay armed until full
// - unit never requests a system reset
// - reset after end run keeps setup, clears arm, flag, break enable
// - other resets load comparator A to match the reset vector
// - default reset: control C0, trigger 40
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
`include "trace_map.svh"
module debug_trace_unit (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic por_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [1:0] core_cof,
    input wire logic [15:0] core_addr,
    input wire logic [7:0] core_data,
    input wire logic core_fetch,
    input wire logic [15:0] core_opcode_addr,
    input wire logic irq_pending,
    output logic halt_request
);
    import trace_pkg::*;

    // ********************************
    // reset release
    // ********************************
    logic rst_m, rst_q, por_m, por_q;

    // both resets assert at once but leave on the clock
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_m <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_q <= rst_m;
        end
    end

    always_ff @(posedge ref_clk or negedge por_n) begin
        if (!por_n) begin
            por_m <= 1'b0;
            por_q <= 1'b0;
        end else begin
            por_m <= 1'b1;
            por_q <= por_m;
        end
    end

    // ********************************
    // state and storage
    // ********************************
    cap_state_t state, next_state;
    logic ctl_en, ctl_brk;
    logic [7:0] trg, cax, cah, cal;
    entry_t fifo [`DEPTH];
    logic [2:0] wr_ptr, rd_ptr;
    logic [3:0] tally;
    logic [15:0] prev_addr;

    // ********************************
    // bus decode
    // ********************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = acc & wb_we_i & wb_sel_i[0];
    wire rd = acc & ~wb_we_i;
    wire wr_ctl = wr & hit(wb_adr_i, `OFF_CTL);
    wire rd_low = rd & hit(wb_adr_i, `OFF_FL);
    wire armed = state != st_idle;

    // reset flavour: an enabled end-mode setup keeps its results, whether still armed or finished
    wire keep_run = ctl_en & ~trg[`TRG_BEGIN_BIT];
    wire hard_init = ~por_q | (~rst_q & ~keep_run);
    wire soft_init = por_q & ~rst_q & keep_run;

    // ********************************
    // trigger and capture decode
    // ********************************
    wire ev_only = trg[`TRG_EVONLY_BIT];
    wire fetch_hit = core_fetch & (core_addr == {cah, cal});
    // qualified trigger lets the interrupt win the pipe slot
    wire trig = armed & fetch_hit & ~(trg[`TRG_QUAL_BIT] & irq_pending);
    wire cof_any = |core_cof;
    wire [15:0] branch_src = prev_addr - `BRANCH_BACK;
    wire [15:0] cof_entry = core_cof[1] ? core_addr : branch_src;
    wire [15:0] cap_entry = ev_only ? {8'h00, core_data} : cof_entry;

    logic store, profile, fill_done;
    logic [15:0] store_data;

    // what enters the buffer this cycle
    always_comb begin
        store = 1'b0;
        case (state)
            st_wait: store = trig & (ev_only | cof_any);
            st_fill: store = ev_only ? (fetch_hit & ~(trg[`TRG_QUAL_BIT] & irq_pending)) : cof_any;
            st_end: store = cof_any & ~(trig & ev_only);
            default: store = 1'b0;
        endcase
    end

    assign profile = (state == st_idle) & rd_low;
    assign store_data = profile ? core_opcode_addr : cap_entry;
    assign fill_done = (state == st_fill || state == st_wait) & store & (tally == `TALLY_LAST);

    // capture sequencer
    always_comb begin
        next_state = state;
        case (state)
            st_wait: begin
                if (fill_done) begin
                    next_state = st_idle;
                end else if (trig) begin
                    next_state = st_fill;
                end
            end
            st_fill: begin
                if (fill_done) begin
                    next_state = st_idle;
                end
            end
            st_end: begin
                if (trig) begin
                    next_state = st_idle;
                end
            end
            default: next_state = st_idle;
        endcase
        if (wr_ctl) begin
            if (wb_dat_i[`CTL_ARM_BIT] & wb_dat_i[`CTL_EN_BIT]) begin
                next_state = trg[`TRG_BEGIN_BIT] ? st_wait : st_end;
            end else begin
                next_state = st_idle;
            end
        end
    end

    wire arm_start = wr_ctl & wb_dat_i[`CTL_ARM_BIT] & wb_dat_i[`CTL_EN_BIT];
    wire [3:0] next_tally = arm_start ? 4'h0 :
        (store & armed & tally != `TALLY_FULL) ? tally + 4'h1 : tally;
    wire [2:0] next_wr = arm_start ? 3'h0 : (store | profile) ? wr_ptr + 3'h1 : wr_ptr;
    wire [2:0] oldest = wr_ptr - tally[2:0];
    // an armed read sees the oldest slot and never moves the pointer
    wire [2:0] rd_idx = armed ? oldest : rd_ptr;

    // ********************************
    // control registers
    // ********************************
    // reset image as a word, so the enable bit is picked without losing bits
    wire [7:0] ctl_rst_val = `CTL_RST;

    // an end-mode trace run is the only thing that may survive a reset on nrst
    always_ff @(posedge ref_clk) begin
        if (hard_init) begin
            ctl_en <= ctl_rst_val[`CTL_EN_BIT];
            ctl_brk <= 1'b0;
            trg <= `TRG_RST;
            cax <= `CAX_RST;
            cah <= `CAH_RST;
            cal <= `CAL_RST;
        end else if (soft_init) begin
            ctl_brk <= 1'b0;
        end else begin
            if (wr_ctl) begin
                ctl_en <= wb_dat_i[`CTL_EN_BIT];
                ctl_brk <= wb_dat_i[`CTL_BRK_BIT];
            end
            if (wr & hit(wb_adr_i, `OFF_TRG)) begin
                trg <= wb_dat_i[7:0];
            end
            if (wr & hit(wb_adr_i, `OFF_CAX)) begin
                cax <= wb_dat_i[7:0];
            end
            if (wr & hit(wb_adr_i, `OFF_CAH)) begin
                cah <= wb_dat_i[7:0];
            end
            if (wr & hit(wb_adr_i, `OFF_CAL)) begin
                cal <= wb_dat_i[7:0];
            end
        end
    end

    // sequencer, tally and pointers
    always_ff @(posedge ref_clk) begin
        if (hard_init) begin
            state <= st_wait;
            tally <= 4'h0;
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
        end else if (soft_init) begin
            state <= st_idle;
        end else begin
            state <= next_state;
            tally <= next_tally;
            wr_ptr <= next_wr;
            if (next_state != st_idle || armed) begin
                rd_ptr <= next_wr - next_tally[2:0];
            end else if (rd_low) begin
                rd_ptr <= rd_ptr + 3'h1;
            end
        end
    end

    // previous address feeds the branch source
    always_ff @(posedge ref_clk) begin
        prev_addr <= core_addr;
    end

    // buffer words; a full end run overwrites the oldest slot
    for (genvar i = 0; i < `DEPTH; i++) begin : g_word
        always_ff @(posedge ref_clk) begin
            if ((store | profile) && wr_ptr == 3'(i)) begin
                fifo[i] <= store_data;
            end
        end
    end

    // ********************************
    // bus answer and halt
    // ********************************
    logic [7:0] rd_mux;

    // unmapped addresses answer with zero
    always_comb begin
        rd_mux = 8'h00;
        if (hit(wb_adr_i, `OFF_CTL)) rd_mux = {ctl_en, armed, ctl_brk, 5'h00};
        if (hit(wb_adr_i, `OFF_TRG)) rd_mux = trg;
        if (hit(wb_adr_i, `OFF_STAT)) rd_mux = {armed, 7'h00};
        if (hit(wb_adr_i, `OFF_CNT)) rd_mux = {4'h0, tally};
        if (hit(wb_adr_i, `OFF_FH)) rd_mux = fifo[rd_idx][15:8];
        if (hit(wb_adr_i, `OFF_FL)) rd_mux = fifo[rd_idx][7:0];
        if (hit(wb_adr_i, `OFF_CAX)) rd_mux = cax;
        if (hit(wb_adr_i, `OFF_CAH)) rd_mux = cah;
        if (hit(wb_adr_i, `OFF_CAL)) rd_mux = cal;
    end

    // halt is the only request going out; there is no reset request
    wire halt_evt = ctl_brk & ((state == st_end & trig) | fill_done);

    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            halt_request <= 1'b0;
        end else begin
            wb_ack_o <= acc;
            wb_dat_o <= rd ? {24'h000000, rd_mux} : 32'h0000_0000;
            halt_request <= halt_evt;
        end
    end

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_q || !por_q);

    AST_COF_DEST: assert property (armed && store && !ev_only && core_cof[1] |-> store_data == core_addr)
        else $error("destination entry is not the core address");
    AST_BRANCH_SRC: assert property (armed && store && !ev_only && core_cof == 2'b01
        |-> store_data == $past(core_addr) - 16'h0002)
        else $error("branch source is not previous address minus two");
    AST_WAIT_EMPTY: assert property (state == st_wait && !trig |-> !store)
        else $error("stored before the begin trigger");
    AST_END_STOP: assert property (state == st_end && trig && !wr_ctl |=> state == st_idle ##1 tally == $past(tally))
        else $error("end trigger did not stop capture");
    AST_END_LAST: assert property (state == st_end && trig && cof_any && !ev_only |-> store)
        else $error("trigger change of flow not stored");
    AST_TALLY_KEEP: assert property (rd_low && !armed && !wr_ctl |=> tally == $past(tally))
        else $error("tally moved on a read");
    AST_LOW_ADV: assert property (rd_low && !armed && !wr_ctl |=> rd_ptr == $past(rd_ptr) + 3'h1)
        else $error("low byte read did not advance");
    AST_ARMED_OLD: assert property (armed |-> rd_idx == wr_ptr - tally[2:0])
        else $error("armed read not at oldest entry");
    AST_PROFILE: assert property (profile |=> fifo[$past(wr_ptr)] == $past(core_opcode_addr))
        else $error("profile sample not captured");
    AST_QUAL: assert property (trg[`TRG_QUAL_BIT] && irq_pending |-> !trig)
        else $error("trigger taken over pending interrupt");
    AST_FILL_FULL: assert property (fill_done && !wr_ctl |=> state == st_idle && tally == 4'h8)
        else $error("begin run did not end at eight words");
    AST_EVONLY_HI: assert property (armed && store && ev_only |-> store_data[15:8] == 8'h00)
        else $error("event entry upper byte not zero");

    // ********************************
    // trigger, interrupt and readout checks
    // ********************************
    // these guard halt, capture and profile rules and the corners that a plain capture run never reaches:
    // interrupts on the trigger fetch, armed reads and the saturated tally
    AST_END_HALT: assert property (ctl_brk && state == st_end && trig && !wr_ctl |=> halt_request)
        else $error("end trigger with break enable gave no halt");

    AST_END_IRQ: assert property (state == st_end && fetch_hit && irq_pending && !trg[`TRG_QUAL_BIT] && !wr_ctl |=> !armed)
        else $error("unqualified end trigger ignored a pending interrupt cycle");

    AST_BEGIN_IRQ: assert property (state == st_wait && fetch_hit && irq_pending && !trg[`TRG_QUAL_BIT] && cof_any |-> store)
        else $error("begin trigger with pending interrupt not recorded");

    AST_FILL_ARMED: assert property (state == st_fill && !fill_done && !wr_ctl |=> armed)
        else $error("begin run disarmed before the buffer was full");

    AST_ARMED_NO_ADV: assert property (armed && rd_low && !store && !wr_ctl |=> wr_ptr == $past(wr_ptr))
        else $error("armed read moved the buffer");

    AST_TALLY_CAP: assert property (tally <= `TALLY_FULL)
        else $error("tally above eight words");

    AST_END_FLOW: assert property (state == st_end && cof_any && !ev_only && !wr_ctl |-> store)
        else $error("end capture dropped a change of flow");

    AST_PROFILE_TALLY: assert property (profile && !wr_ctl |=> tally == $past(tally))
        else $error("profile sample changed the tally");

    COV_FILL: cover property (fill_done);
    COV_END_TRIG: cover property (state == st_end && trig);
    COV_PROFILE: cover property (profile);
    COV_SUPPRESS: cover property (armed && fetch_hit && irq_pending && trg[`TRG_QUAL_BIT]);
    COV_EVENT: cover property (armed && store && ev_only);
endmodule

// ---- tb/core_model.sv ----
`timescale 1ns/1ns
// ************************
// cpu core stand-in
// ************************
module core_model (
    input wire logic ref_clk,
    input wire logic cmd_v,
    input wire logic [1:0] cmd_cof,
    input wire logic [15:0] cmd_addr,
    input wire logic cmd_fetch,
    input wire logic cmd_irq,
    output logic [1:0] core_cof,
    output logic [15:0] core_addr,
    output logic [7:0] core_data,
    output logic core_fetch,
    output logic [15:0] core_opcode_addr,
    output logic irq_pending
);
    logic [15:0] last_addr = 16'h0000;
    // idle address is the inverse of the last one, so a stale value never looks valid
    assign core_addr = cmd_v ? cmd_addr : ~last_addr;
    assign core_cof = cmd_v ? cmd_cof : 2'b00;
    assign core_fetch = cmd_v & cmd_fetch;
    assign irq_pending = cmd_v & cmd_irq;
    assign core_data = core_addr[7:0] ^ 8'h5A;
    assign core_opcode_addr = core_addr + 16'h0001;
    // previous address feeds the idle pattern
    always @(posedge ref_clk) begin
        last_addr <= core_addr;
    end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`include "trace_map.svh"
// ************************
// trace unit bench
// ************************
module tb;
    logic ref_clk, nrst, por_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, halt_request;
    logic cmd_v, cmd_fetch, cmd_irq, irq_pending, core_fetch;
    logic [7:0] wb_adr_i, core_data, rd;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [1:0] cmd_cof, core_cof;
    logic [15:0] cmd_addr, core_addr, core_opcode_addr;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int halts = 0;
    debug_trace_unit debug_trace_unit_inst (.ref_clk(ref_clk), .nrst(nrst), .por_n(por_n),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .core_cof(core_cof), .core_addr(core_addr), .core_data(core_data), .core_fetch(core_fetch),
        .core_opcode_addr(core_opcode_addr), .irq_pending(irq_pending), .halt_request(halt_request));
    core_model core_model_inst (.ref_clk(ref_clk), .cmd_v(cmd_v), .cmd_cof(cmd_cof), .cmd_addr(cmd_addr),
        .cmd_fetch(cmd_fetch), .cmd_irq(cmd_irq), .core_cof(core_cof), .core_addr(core_addr),
        .core_data(core_data), .core_fetch(core_fetch), .core_opcode_addr(core_opcode_addr),
        .irq_pending(irq_pending));
    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // hang guard and break pulse tally
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (halt_request === 1'b1) halts <= halts + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            report_and_stop();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks = total_checks + 1;
        if (seen !== want) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    // classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, 24'h000000, d};
        @(posedge ref_clk);
        while (wb_ack_o !== 1'b1) @(posedge ref_clk);
        rd = wb_dat_o[7:0];
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] want);
        wb(1'b0, a, 8'h00);
        check({8'h00, rd}, {8'h00, want});
    endtask
    task automatic step(input logic [1:0] c, input logic [15:0] a, input logic f, input logic i);
        @(posedge ref_clk);
        {cmd_v, cmd_cof, cmd_addr, cmd_fetch, cmd_irq} <= {1'b1, c, a, f, i};
    endtask
    task automatic idle();
        @(posedge ref_clk);
        cmd_v <= 1'b0;
    endtask
    task automatic do_reset(input logic por);
        @(posedge ref_clk);
        {nrst, por_n} <= {1'b0, ~por};
        repeat (6) @(posedge ref_clk);
        {nrst, por_n} <= 2'b11;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic test_defaults();
        do_reset(1'b1);
        rchk(`OFF_CTL, 8'hC0);
        rchk(`OFF_TRG, 8'h40);
        rchk(`OFF_CAX, 8'h00);
        rchk(`OFF_CAH, 8'hFF);
        rchk(`OFF_CAL, 8'hFE);
        rchk(`OFF_STAT, 8'h80);
        rchk(8'h24, 8'h00);
        $display("test defaults done");
    endtask
    // default setup waits for a fetch of FFFE; that fetch carries a pending interrupt
    task automatic test_begin();
        logic [15:0] e;
        step(2'b10, 16'h1234, 1'b0, 1'b0);
        step(2'b10, 16'hFFFE, 1'b1, 1'b1);
        for (int i = 1; i < 7; i++) step(2'b10, 16'h2000 + 16'(i), 1'b0, 1'b0);
        step(2'b00, 16'h3100, 1'b0, 1'b0);
        step(2'b01, 16'h3300, 1'b0, 1'b0);
        step(2'b10, 16'h4000, 1'b0, 1'b0);
        idle();
        rchk(`OFF_STAT, 8'h00);
        rchk(`OFF_CNT, 8'h08);
        rchk(`OFF_CTL, 8'h80);
        for (int i = 0; i < 8; i++) begin
            e = (i == 0) ? 16'hFFFE : (i == 7) ? 16'h30FE : 16'h2000 + 16'(i);
            rchk(`OFF_FH, e[15:8]);
            rchk(`OFF_FL, e[7:0]);
        end
        rchk(`OFF_CNT, 8'h08);
        $display("test begin done");
    endtask
    task automatic test_end();
        wb(1'b1, `OFF_TRG, 8'h00);
        wb(1'b1, `OFF_CAH, 8'h12);
        wb(1'b1, `OFF_CAL, 8'h00);
        wb(1'b1, `OFF_CTL, 8'hE0);
        for (int i = 0; i < 3; i++) step(2'b10, 16'h50A0 + 16'(i), 1'b0, 1'b0);
        idle();
        rchk(`OFF_FL, 8'hA0);
        rchk(`OFF_FL, 8'hA0);
        rchk(`OFF_STAT, 8'h80);
        for (int i = 3; i < 10; i++) step(2'b10, 16'h50A0 + 16'(i), 1'b0, 1'b0);
        step(2'b10, 16'h1200, 1'b1, 1'b0);
        idle();
        repeat (2) @(posedge ref_clk);
        check(16'(halts), 16'h0001);
        rchk(`OFF_CTL, 8'hA0);
        rchk(`OFF_STAT, 8'h00);
        for (int i = 0; i < 8; i++) rchk(`OFF_FL, (i == 7) ? 8'h00 : 8'hA3 + 8'(i));
        $display("test end done");
    endtask
    // warm reset after an end run keeps the results readable
    task automatic test_warm();
        do_reset(1'b0);
        rchk(`OFF_CTL, 8'h80);
        rchk(`OFF_STAT, 8'h00);
        rchk(`OFF_CNT, 8'h08);
        rchk(`OFF_CAH, 8'h12);
        $display("test warm done");
    endtask
    task automatic test_irq();
        wb(1'b1, `OFF_TRG, 8'h80);
        wb(1'b1, `OFF_CTL, 8'hC0);
        step(2'b10, 16'h1200, 1'b1, 1'b1);
        idle();
        rchk(`OFF_STAT, 8'h80);
        wb(1'b1, `OFF_TRG, 8'h00);
        step(2'b10, 16'h1200, 1'b1, 1'b1);
        idle();
        rchk(`OFF_STAT, 8'h00);
        rchk(`OFF_CTL, 8'h80);
        $display("test irq done");
    endtask
    // event-only begin run: eight fetches of the target store data bytes
    task automatic test_event();
        wb(1'b1, `OFF_TRG, 8'h50);
        wb(1'b1, `OFF_CAH, 8'h12);
        wb(1'b1, `OFF_CAL, 8'h40);
        wb(1'b1, `OFF_CTL, 8'hC0);
        for (int i = 0; i < 8; i++) step(2'b00, 16'h1240, 1'b1, 1'b0);
        idle();
        rchk(`OFF_STAT, 8'h00);
        rchk(`OFF_CNT, 8'h08);
        rchk(`OFF_FH, 8'h00);
        for (int i = 0; i < 8; i++) rchk(`OFF_FL, 8'h1A);
        $display("test event done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // inputs settled at time zero, then the scenarios in order
    initial begin
        {nrst, por_n, wb_cyc_i, wb_stb_i, wb_we_i, cmd_v, cmd_fetch, cmd_irq} = 8'h00;
        {wb_adr_i, wb_dat_i, cmd_cof, cmd_addr} = 58'h0;
        wb_sel_i = 4'hF;
        test_defaults();
        test_begin();
        test_end();
        test_warm();
        test_irq();
        test_event();
        report_and_stop();
    end
endmodule
